// >>> rtl/valve_ctrl_defs.vh
// Summary of operation
// - each channel holds a control mode 0..6 selecting permitted paths
// - mode 0 honours remote reconnect, write connected and write ready; no disconnection
// - remote disconnect goes to disconnected only when mode is above zero
// - remote reconnect in modes 1,3,5,6 goes to ready for reconnection
// - remote reconnect in modes 2 and 4 goes straight to connected
// - nonzero modes accept manual reconnection from the far device key
// - unsupported far-device transitions never corrupt channel state
// - valveless device: output and control state forced to 1, commands rejected
// - control and scripts act only for bidirectional devices with a valve
// - one shared schedule fires one selected script for all channels
// - schedule type resets to 1
// - selected script runs when current date and time match stored time
// - script table holds sixteen scripts over the four channels
// - odd scripts 1..7 write ready, even 2..8 write connected, channels 1..4
// - scripts 9,11,13,15 remote disconnect channels 1..4
// - scripts 10,12,14,16 remote reconnect channels 1..4
// - control state: 0 disconnected, 1 connected, 2 ready for reconnection
// - output state reports physical valve position, 0 false, 1 true
`ifndef VALVE_CTRL_DEFS_VH
`define VALVE_CTRL_DEFS_VH
`define ADDR_MODE0      4'h0
`define ADDR_MODE1      4'h1
`define ADDR_MODE2      4'h2
`define ADDR_MODE3      4'h3
`define ADDR_STATE      4'h4
`define ADDR_CMD        4'h5
`define ADDR_SCHED_SEL  4'h6
`define ADDR_SCHED_TYPE 4'h7
`define ADDR_SCHED_TIME 4'h8
`define ADDR_SCHED_DATE 4'h9
`define ADDR_NOW_TIME   4'hA
`define ADDR_NOW_DATE   4'hB
`define ADDR_DEVCAP     4'hC
`define CS_DISC         2'h0
`define CS_CONN         2'h1
`define CS_READY        2'h2
`define MODE_MAX        3'h6
`define MODE_RESET      3'h0
`define TYPE_RESET      8'h01
`define DATE_WILDCARD   32'hFFFF_FFFF
`define CMD_DISC        2'h1
`define CMD_RECON       2'h2
`define CMD_WR_READY    2'h3
`endif

// >>> rtl/valve_channel.v
`timescale 1ns/1ps
`include "valve_ctrl_defs.vh"
// one disconnect channel: mode, control state and valve tracking
module valve_channel (
    input  wire       mclk,       // system clock
    input  wire       srst,       // sync reset, active high
    input  wire       hasValve,   // device is bidirectional with a valve
    input  wire [2:0] mode,       // control mode 0..6
    input  wire       cmdDisc,    // remote disconnect pulse
    input  wire       cmdRecon,   // remote reconnect pulse
    input  wire       wrReady,    // internal write ready pulse
    input  wire       wrConn,     // internal write connected pulse
    input  wire       keyRecon,   // manual key reconnect, synchronised pulse
    input  wire       valveOpen,  // physical valve position, synchronised
    output reg  [1:0] ctrlState_q,// control state
    output reg        outState_q  // output state
);
    reg [1:0] ctrlState_d;
    wire directRecon = (mode == 3'h2) || (mode == 3'h4);

    // next control state; unknown commands fall through leaving the state alone
    always @* begin
        ctrlState_d = ctrlState_q;
        if (!hasValve) begin
            ctrlState_d = `CS_CONN;
        end else if (wrConn) begin
            ctrlState_d = `CS_CONN;
        end else if (wrReady) begin
            ctrlState_d = `CS_READY;
        end else if (cmdDisc) begin
            if (mode != 3'h0)
                ctrlState_d = `CS_DISC;
        end else if (cmdRecon) begin
            if (mode == 3'h0)
                ctrlState_d = `CS_CONN;
            else if (directRecon)
                ctrlState_d = `CS_CONN;
            else if (mode <= `MODE_MAX)
                ctrlState_d = `CS_READY;
        end else if (keyRecon && mode != 3'h0 && ctrlState_q == `CS_READY) begin
            ctrlState_d = `CS_CONN;
        end
    end

    // state flops; out-of-range codes never appear because only legal codes load
    always @(posedge mclk) begin
        if (srst) begin
            ctrlState_q <= `CS_CONN;
            outState_q  <= 1'b0;
        end else begin
            ctrlState_q <= ctrlState_d;
            outState_q  <= hasValve ? valveOpen : 1'b1;
        end
    end
endmodule

// >>> rtl/valve_disconnect_control.v
`timescale 1ns/1ps
`include "valve_ctrl_defs.vh"
// four-channel valve disconnect control with one shared schedule
module valve_disconnect_control #(
    parameter NCH = 4                 // channel count
) (
    input  wire        mclk,          // system clock, 125 MHz
    input  wire        srst,          // sync reset, active high
    input  wire [3:0]  regAddr,       // register word address
    input  wire [31:0] regWdata,      // write data
    input  wire        regWr,         // write strobe
    input  wire        regRd,         // read strobe
    output reg  [31:0] regRdata_q,    // read data, cycle after strobe
    input  wire [3:0]  valveOpenPin,  // physical valve position per channel
    input  wire [3:0]  keyPressPin,   // manual reconnect key per channel
    input  wire [3:0]  hasValvePin,   // device bidirectional with valve
    output reg  [7:0]  ctrlStates_q,  // control states, 2 bits per channel
    output reg  [3:0]  outStates_q,   // output states per channel
    output reg  [4:0]  firedScript_q  // last script fired by the schedule
);
    // pin synchronisers, two flops each for valve and capability, three for the key to allow edge detection
    reg [3:0] valveS1_q, valveS2_q, keyS1_q, keyS2_q, keyS3_q, capS1_q, capS2_q;
    always @(posedge mclk) begin
        if (srst) begin
            valveS1_q <= 4'h0;
            valveS2_q <= 4'h0;
            keyS1_q   <= 4'h0;
            keyS2_q   <= 4'h0;
            keyS3_q   <= 4'h0;
            capS1_q   <= 4'h0;
            capS2_q   <= 4'h0;
        end else begin
            valveS1_q <= valveOpenPin;
            valveS2_q <= valveS1_q;
            keyS1_q   <= keyPressPin;
            keyS2_q   <= keyS1_q;
            keyS3_q   <= keyS2_q;
            capS1_q   <= hasValvePin;
            capS2_q   <= capS1_q;
        end
    end
    wire [3:0] keyRise = keyS2_q & ~keyS3_q;   // one pulse per key press

    // software registers
    reg [2:0]  mode_q [0:3];
    reg [4:0]  schedSel_q;
    reg [7:0]  schedType_q;
    reg [31:0] schedTime_q, schedDate_q, nowTime_q, nowDate_q;
    reg        schedArmed_q;
    integer    i;

    // command register decode: [1:0] command, [3:2] channel
    wire       cmdWr  = regWr && regAddr == `ADDR_CMD;
    wire [1:0] cmdCh  = regWdata[3:2];
    wire [1:0] cmdOp  = regWdata[1:0];

    // schedule match; wildcard date matches any day
    wire dateHit = (schedDate_q == `DATE_WILDCARD) || (schedDate_q == nowDate_q);
    wire fire    = schedArmed_q && dateHit && (schedTime_q == nowTime_q);

    // script decode: 1..8 write state, 9..16 call methods
    wire [3:0] sIdx   = schedSel_q[3:0] - 4'h1;
    wire       sValid = fire && schedSel_q >= 5'h01 && schedSel_q <= 5'h10;
    wire [1:0] sCh    = sIdx[2:1];
    wire       sMeth  = sIdx[3];
    wire       sEven  = sIdx[0];   // zero-based odd index means an even script

    // register writes and schedule arming; firing disarms until re-armed by a write
    always @(posedge mclk) begin
        if (srst) begin
            for (i = 0; i < 4; i = i + 1)
                mode_q[i] <= `MODE_RESET;
            schedSel_q   <= 5'h00;
            schedType_q  <= `TYPE_RESET;
            schedTime_q  <= 32'h0000_0000;
            schedDate_q  <= 32'h0000_0000;
            nowTime_q    <= 32'h0000_0000;
            nowDate_q    <= 32'h0000_0000;
            schedArmed_q <= 1'b0;
        end else begin
            if (fire)
                schedArmed_q <= 1'b0;
            if (regWr) begin
                // whole word compared, so a value of 8 or more cannot alias onto a legal mode
                if (regAddr == `ADDR_MODE0) begin
                    if (regWdata <= {29'h0, `MODE_MAX}) mode_q[0] <= regWdata[2:0];
                end else if (regAddr == `ADDR_MODE1) begin
                    if (regWdata <= {29'h0, `MODE_MAX}) mode_q[1] <= regWdata[2:0];
                end else if (regAddr == `ADDR_MODE2) begin
                    if (regWdata <= {29'h0, `MODE_MAX}) mode_q[2] <= regWdata[2:0];
                end else if (regAddr == `ADDR_MODE3) begin
                    if (regWdata <= {29'h0, `MODE_MAX}) mode_q[3] <= regWdata[2:0];
                end else if (regAddr == `ADDR_SCHED_SEL) begin
                    schedSel_q   <= regWdata[4:0];
                    schedArmed_q <= 1'b1;
                end else if (regAddr == `ADDR_SCHED_TYPE) begin
                    schedType_q  <= regWdata[7:0];
                end else if (regAddr == `ADDR_SCHED_TIME) begin
                    schedTime_q  <= regWdata;
                    schedArmed_q <= 1'b1;
                end else if (regAddr == `ADDR_SCHED_DATE) begin
                    schedDate_q  <= regWdata;
                    schedArmed_q <= 1'b1;
                end else if (regAddr == `ADDR_NOW_TIME) begin
                    nowTime_q    <= regWdata;
                end else if (regAddr == `ADDR_NOW_DATE) begin
                    nowDate_q    <= regWdata;
                end
            end
        end
    end

    // per-channel command pulses; software may only issue method commands
    wire [3:0] chDisc, chRecon, chReady, chConn;
    wire [1:0] chState [0:3];
    wire [3:0] chOut;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : chan
            localparam integer GI = g;
            wire [1:0] gch = GI[1:0];
            assign chDisc[g]  = (cmdWr && cmdCh == gch && cmdOp == `CMD_DISC)
                              || (sValid && sMeth && !sEven && sCh == gch);
            assign chRecon[g] = (cmdWr && cmdCh == gch && cmdOp == `CMD_RECON)
                              || (sValid && sMeth && sEven && sCh == gch);
            assign chReady[g] = sValid && !sMeth && !sEven && sCh == gch;
            assign chConn[g]  = sValid && !sMeth && sEven && sCh == gch;
            valve_channel u_ch (
                .mclk        (mclk),
                .srst        (srst),
                .hasValve    (capS2_q[g]),
                .mode        (mode_q[g]),
                .cmdDisc     (chDisc[g]),
                .cmdRecon    (chRecon[g]),
                .wrReady     (chReady[g]),
                .wrConn      (chConn[g]),
                .keyRecon    (keyRise[g]),
                .valveOpen   (valveS2_q[g]),
                .ctrlState_q (chState[g]),
                .outState_q  (chOut[g])
            );
        end
    endgenerate

    // registered outputs and read port
    always @(posedge mclk) begin
        if (srst) begin
            regRdata_q    <= 32'h0000_0000;
            ctrlStates_q  <= 8'h55;
            outStates_q   <= 4'h0;
            firedScript_q <= 5'h00;
        end else begin
            ctrlStates_q <= {chState[3], chState[2], chState[1], chState[0]};
            outStates_q  <= chOut;
            if (sValid)
                firedScript_q <= schedSel_q;
            regRdata_q <= 32'h0000_0000;
            if (regRd) begin
                if (regAddr == `ADDR_MODE0)           regRdata_q <= {29'h0, mode_q[0]};
                else if (regAddr == `ADDR_MODE1)      regRdata_q <= {29'h0, mode_q[1]};
                else if (regAddr == `ADDR_MODE2)      regRdata_q <= {29'h0, mode_q[2]};
                else if (regAddr == `ADDR_MODE3)      regRdata_q <= {29'h0, mode_q[3]};
                else if (regAddr == `ADDR_STATE)
                    regRdata_q <= {20'h0, chOut, chState[3], chState[2], chState[1], chState[0]};
                else if (regAddr == `ADDR_SCHED_SEL)  regRdata_q <= {26'h0, schedArmed_q, schedSel_q};
                else if (regAddr == `ADDR_SCHED_TYPE) regRdata_q <= {24'h0, schedType_q};
                else if (regAddr == `ADDR_SCHED_TIME) regRdata_q <= schedTime_q;
                else if (regAddr == `ADDR_SCHED_DATE) regRdata_q <= schedDate_q;
                else if (regAddr == `ADDR_NOW_TIME)   regRdata_q <= nowTime_q;
                else if (regAddr == `ADDR_NOW_DATE)   regRdata_q <= nowDate_q;
                else if (regAddr == `ADDR_DEVCAP)     regRdata_q <= {28'h0, capS2_q};
            end
        end
    end
endmodule

// >>> tb/valve_disconnect_control_chk.sv
`timescale 1ns/1ps
module valve_disconnect_control_chk #(
    parameter NCH = 4             // channel count
) (
    input wire        mclk,         // clock
    input wire        srst,         // sync reset
    input wire [3:0]  regAddr,      // address
    input wire [31:0] regWdata,     // write data
    input wire        regWr,        // write strobe
    input wire        regRd,        // read strobe
    input wire [31:0] regRdata_q,   // read data
    input wire [3:0]  valveOpenPin, // valve position
    input wire [3:0]  keyPressPin,  // manual key
    input wire [3:0]  hasValvePin,  // valve present
    input wire [7:0]  ctrlStates_q, // control states
    input wire [3:0]  outStates_q,  // output states
    input wire [4:0]  firedScript_q // fired script
);
    reg  [2:0] modeMirror_q;
    wire       cmdHit = regWr && regAddr == 4'h5 && regWdata[3:2] == 2'h0 && hasValvePin[0];
    // mirror of channel 0 mode; writes above 6 are dropped
    always @(posedge mclk) begin
        if (srst)
            modeMirror_q <= 3'h0;
        else if (regWr && regAddr == 4'h0 && regWdata <= 32'h0000_0006)
            modeMirror_q <= regWdata[2:0];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    AST_STATE_LEGAL: assert property (
        ctrlStates_q[1:0] != 2'h3 && ctrlStates_q[7:6] != 2'h3) else $error("bad state code");
    AST_FIRED_RANGE: assert property (firedScript_q <= 5'h10) else $error("bad script");
    AST_NO_VALVE: assert property (
        !hasValvePin[3] [*6] |-> ctrlStates_q[7:6] == 2'h1 && outStates_q[3]) else $error("valveless");
    AST_MODE0_HOLD: assert property (
        cmdHit && regWdata[1:0] == 2'h1 && modeMirror_q == 3'h0
        |-> ##2 ctrlStates_q[1:0] == $past(ctrlStates_q[1:0], 2)) else $error("mode 0 disc");
    AST_DISC_MODE: assert property (
        cmdHit && regWdata[1:0] == 2'h1 && modeMirror_q != 3'h0
        |-> ##2 ctrlStates_q[1:0] == 2'h0) else $error("disc failed");
    AST_RECON_MODE: assert property (
        cmdHit && regWdata[1:0] == 2'h2 && modeMirror_q != 3'h0 |-> ##2 ctrlStates_q[1:0] ==
        (($past(modeMirror_q, 2) == 3'h2 || $past(modeMirror_q, 2) == 3'h4) ? 2'h1 : 2'h2))
        else $error("recon wrong");
    AST_OTHER_CHAN: assert property (
        cmdHit |-> ##2 ctrlStates_q[7:2] == $past(ctrlStates_q[7:2], 2)) else $error("crosstalk");
    AST_MODE_READ: assert property (
        $past(regRd) && $past(regAddr) == 4'h0 |-> regRdata_q == {29'h0, modeMirror_q})
        else $error("mode read");
endmodule
bind valve_disconnect_control valve_disconnect_control_chk #(.NCH(NCH)) chk_u (
    .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata_q(regRdata_q), .valveOpenPin(valveOpenPin),
    .keyPressPin(keyPressPin), .hasValvePin(hasValvePin), .ctrlStates_q(ctrlStates_q),
    .outStates_q(outStates_q), .firedScript_q(firedScript_q));

// >>> tb/valve_device_model.sv
`timescale 1ns/1ps
module valve_device_model #(
    parameter [3:0] HAS_VALVE = 4'h7 // channel 3 has no valve
) (
    input  wire       mclk,         // clock
    input  wire [7:0] ctrlStates_q, // commanded states
    output reg  [3:0] valveOpenPin, // valve position
    output reg  [3:0] keyPressPin,  // manual key
    output wire [3:0] hasValvePin   // valve present
);
    reg [3:0] stage1_q = 4'h0;
    reg [3:0] stage2_q = 4'h0;
    integer i;
    assign hasValvePin = HAS_VALVE;
    initial valveOpenPin = 4'h0;
    initial keyPressPin = 4'h0;
    // the valve is slow: it follows the commanded state three cycles late
    always @(posedge mclk) begin
        for (i = 0; i < 4; i = i + 1)
            stage1_q[i] <= HAS_VALVE[i] && ctrlStates_q[2*i+:2] == 2'h1;
        stage2_q <= stage1_q;
        valveOpenPin <= stage2_q;
    end
    // key held a few cycles so the synchroniser sees one rising edge
    task press(input integer ch);
        @(posedge mclk) keyPressPin[ch] <= 1'b1;
        repeat (3) @(posedge mclk);
        keyPressPin[ch] <= 1'b0;
    endtask
endmodule

// >>> tb/valve_disconnect_control_tb.sv
`timescale 1ns/1ps
module valve_disconnect_control_tb;
    reg mclk = 0, srst = 1, regWr = 0, regRd = 0;
    reg [3:0] regAddr = 4'h0;
    reg [31:0] regWdata = 32'h0, rdVal;
    wire [31:0] regRdata_q;
    wire [3:0] valveOpenPin, keyPressPin, hasValvePin, outStates_q;
    wire [7:0] ctrlStates_q;
    wire [4:0] firedScript_q;
    integer fail_count = 0, total_checks = 0, m, k;
    always #4 mclk = ~mclk;
    valve_disconnect_control dut_u (.mclk(mclk), .srst(srst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q),
        .valveOpenPin(valveOpenPin), .keyPressPin(keyPressPin), .hasValvePin(hasValvePin),
        .ctrlStates_q(ctrlStates_q), .outStates_q(outStates_q), .firedScript_q(firedScript_q));
    valve_device_model dev_u (.mclk(mclk), .ctrlStates_q(ctrlStates_q),
        .valveOpenPin(valveOpenPin), .keyPressPin(keyPressPin), .hasValvePin(hasValvePin));
    task check(input [8*8-1:0] name, input [31:0] got, input [31:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("ERROR %0s exp %h got %h", name, exp, got);
        end
    endtask
    task wr(input [3:0] a, input [31:0] d);
        @(posedge mclk) {regWr, regAddr, regWdata} <= {1'b1, a, d};
        @(posedge mclk) regWr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe, so sample just past that edge
    task rd(input [3:0] a);
        @(posedge mclk) {regRd, regAddr} <= {1'b1, a};
        @(posedge mclk) regRd <= 1'b0;
        #1 rdVal = regRdata_q;
    endtask
    task cmd(input [1:0] ch, input [1:0] op);
        wr(4'h5, {28'h0, ch, op});
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task complete_run;
        $display("checks %0d errors %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task t_reset_modes;
        rd(4'h7); check("type", rdVal, 32'h1);
        check("states", {24'h0, ctrlStates_q}, 32'h55);
        wr(4'h1, 32'h7); rd(4'h1); check("mode7", rdVal, 32'h0);
        wr(4'h1, 32'h6); rd(4'h1); check("mode6", rdVal, 32'h6);
        cmd(2'h0, 2'h1); check("m0disc", ctrlStates_q[1:0], 2'h1);
    endtask
    task t_channel;
        for (m = 1; m <= 6; m = m + 1) begin
            wr(4'h0, m); rd(4'h0); check("mode0", rdVal, m);
            cmd(2'h0, 2'h1); check("disc", ctrlStates_q[1:0], 2'h0);
            check("others", ctrlStates_q[7:2], 6'h15);
            // the valve lags its command, so the closed position shows some cycles later
            repeat (5) @(posedge mclk);
            #1 check("vclosed", outStates_q[0], 1'b0);
            cmd(2'h0, 2'h2);
            check("recon", ctrlStates_q[1:0], (m == 2 || m == 4) ? 1 : 2);
            dev_u.press(0);
            repeat (10) @(posedge mclk);
            #1 check("key", ctrlStates_q[1:0], 2'h1);
            check("valve", outStates_q[0], 1'b1);
        end
        // 8 must be refused as a whole, not folded onto mode 0
        wr(4'h0, 32'h8); rd(4'h0); check("mode8", rdVal, 32'h6);
    endtask
    task t_novalve;
        wr(4'h3, 32'h1); cmd(2'h3, 2'h1);
        check("nvstate", ctrlStates_q[7:6], 2'h1);
        check("nvout", outStates_q[3], 1'b1);
        rd(4'hC); check("caps", rdVal[3:0], 4'h7);
    endtask
    // ch 1 scripts: remote disc, remote recon to ready, write connected, write ready
    task t_sched;
        wr(4'h1, 32'h1);
        for (k = 0; k < 4; k = k + 1) begin
            // selector picked from channel and command: 11, 12 methods; 4, 3 internal writes
            wr(4'h8, k + 1); wr(4'h9, 32'hFFFF_FFFF);
            wr(4'h6, k == 0 ? 11 : k == 1 ? 12 : 6 - k);
            wr(4'hA, k + 1);
            repeat (4) @(posedge mclk);
            #1;
            check("fired", firedScript_q, k == 0 ? 11 : k == 1 ? 12 : 6 - k);
            check("script", ctrlStates_q[3:2], k == 2 ? 1 : k ? 2 : 0);
        end
        // exact date: no firing on the wrong day, fires once the day arrives
        wr(4'h9, 32'h0000_0005); wr(4'h8, 32'h0000_0009); wr(4'h6, 32'h0000_0004);
        wr(4'hB, 32'h0000_0004); wr(4'hA, 32'h0000_0009);
        repeat (4) @(posedge mclk);
        #1 check("nofire", firedScript_q, 32'h3);
        check("nostate", ctrlStates_q[3:2], 2'h2);
        wr(4'hB, 32'h0000_0005);
        repeat (4) @(posedge mclk);
        #1 check("dated", firedScript_q, 32'h4);
        check("dstate", ctrlStates_q[3:2], 2'h1);
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        repeat (6) @(posedge mclk);
        t_reset_modes; t_channel; t_novalve; t_sched;
        complete_run;
    end
    initial begin
        #200000 fail_count = fail_count + 1;
        complete_run;
    end
endmodule
